// File: mfv_csr.sv
`timescale 1ns/10ps
// Operation
// - the phy word holds read-back data after a management read and the value to send before a write.
// - a generated pause frame carries the 16-bit pause time held in the flow register.
// - pause time, pass-pause and busy act only while the mac runs full duplex.
// - with flow control on in full duplex, pause frames are decoded and their filter bit follows pass-pause.
// - flow control off does nothing; on means pause frames in full duplex, back-pressure in half.
// - busy returns to 0 once the pause frame has gone out successfully.
// - a non-zero match of the first tag but not the second with bytes 13/14 raises the frame limit to 1522 bytes.
// - a non-zero match of the second tag with bytes 13/14 raises the frame limit to 1538 bytes.
// - the 32-bit data port reaches four wake filters in eight successive accesses.
// - skip-address 0 needs address filter and wake filter; 1 needs the wake filter alone.
// - a wake event from a wake frame sets its flag; writing 1 clears it.
// - a wake event from a remote wake packet sets its flag; writing 1 clears it.
// - both wake flags clear only on power-on reset and survive every other reset.
// - setting the wake-frame enable enters sleep and lets wake frames wake the mac.
// - setting the remote-wake enable enters sleep and lets remote packets wake the mac.
module mfv_csr
  import mfv_pkg::*;
(
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                por_i,
  // wishbone slave
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [7:0]                          wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  output logic                                     wb_ack_o,
  // mac datapath
  input  wire logic                                full_duplex_i,
  input  wire logic                                pause_tx_done_i,
  input  wire logic                                phy_read_done_i,
  input  wire logic [15:0]                         phy_read_word_i,
  input  wire mfv_rx_evt_s                         rx_evt_i,
  output logic                                     pause_tx_req_o,
  output logic      [15:0]                         pause_time_o,
  output logic                                     back_pressure_o,
  output logic                                     rx_pause_decoded_o,
  output logic                                     rx_pause_filter_o,
  output logic      [10:0]                         max_frame_len_o,
  output logic      [15:0]                         phy_transfer_word_o,
  output logic      [WAKE_WORDS*WAKE_WIDTH-1:0]    wake_filter_words_o,
  output logic                                     sleep_mode_o,
  output logic                                     wake_event_o,
  output logic                                     irq_o
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic              ack_ff;
  logic [31:0]       rdata_ff;
  logic              req;
  logic              wr;
  logic [7:0]        adr;
  logic [31:0]       nxt_rdata;
  logic [31:0]       port_rdata;

  // one access per request; the ack cycle itself is not a new request
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr  = req & wb_we_i;
  assign adr = {wb_adr_i[7:2], 2'b00};

  logic hit_phy;
  logic hit_flow;
  logic hit_vl1;
  logic hit_vl2;
  logic hit_port;
  logic hit_wake;
  logic hit_sts;
  logic hit_mask;

  assign hit_phy  = adr == ADR_PHY_DATA;
  assign hit_flow = adr == ADR_FLOW;
  assign hit_vl1  = adr == ADR_VLAN_1;
  assign hit_vl2  = adr == ADR_VLAN_2;
  assign hit_port = adr == ADR_WAKE_DATA;
  assign hit_wake = adr == ADR_WAKE_CTRL;
  assign hit_sts  = adr == ADR_IRQ_STS;
  assign hit_mask = adr == ADR_IRQ_MASK;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [15:0]       phy_word_ff;
  logic [15:0]       pause_time_ff;
  logic              pass_pause_frames_ff;
  logic              flow_control_on_ff;
  logic              busy_ff;
  logic [15:0]       first_tag_identifier_ff;
  logic [15:0]       second_tag_identifier_ff;
  logic              wake_skip_address_filter_ff;
  logic              wake_frame_sleep_enable_ff;
  logic              remote_wake_sleep_enable_ff;
  logic              wake_frame_seen_flag_ff;
  logic              remote_wake_packet_flag_ff;
  logic [IRQ_W-1:0]  irq_sts_ff;
  logic [IRQ_W-1:0]  irq_mask_ff;

  // write-one-to-clear strobes for the wake flags, byte 0 only
  logic              clr_frm;
  logic              clr_rmt;
  assign clr_frm = wr & hit_wake & wb_sel_i[0] & wb_dat_i[WK_FRM_FLAG];
  assign clr_rmt = wr & hit_wake & wb_sel_i[0] & wb_dat_i[WK_RMT_FLAG];

  // byte-lane merges kept 32 bits wide; only the low half is stored
  logic [31:0]       merge_phy;
  logic [31:0]       merge_vl1;
  logic [31:0]       merge_vl2;
  assign merge_phy = mfv_merge({16'h0000, phy_word_ff}, wb_dat_i, wb_sel_i);
  assign merge_vl1 = mfv_merge({16'h0000, first_tag_identifier_ff}, wb_dat_i, wb_sel_i);
  assign merge_vl2 = mfv_merge({16'h0000, second_tag_identifier_ff}, wb_dat_i, wb_sel_i);

  // phy transfer word: software write, engine read-back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phy_word_ff <= '0;
    end else if (phy_read_done_i) begin
      phy_word_ff <= phy_read_word_i;
    end else if (wr && hit_phy) begin
      phy_word_ff <= merge_phy[15:0];
    end
  end

  // flow control fields except busy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pause_time_ff        <= PAUSE_RST;
      pass_pause_frames_ff <= 1'b0;
      flow_control_on_ff   <= 1'b0;
    end else if (wr && hit_flow) begin
      if (wb_sel_i[2]) begin
        pause_time_ff[7:0] <= wb_dat_i[FC_PAUSE_LSB +: 8];
      end
      if (wb_sel_i[3]) begin
        pause_time_ff[15:8] <= wb_dat_i[FC_PAUSE_LSB+8 +: 8];
      end
      if (wb_sel_i[0]) begin
        pass_pause_frames_ff <= wb_dat_i[FC_PASS_BIT];
        flow_control_on_ff   <= wb_dat_i[FC_ON_BIT];
      end
    end
  end

  // busy: a request only counts in full duplex with flow control on
  logic busy_set;
  assign busy_set = wr & hit_flow & wb_sel_i[0] & wb_dat_i[FC_BUSY_BIT]
                    & full_duplex_i & flow_control_on_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
    end else if (busy_set) begin
      busy_ff <= 1'b1;
    end else if (pause_tx_done_i) begin
      busy_ff <= 1'b0;
    end
  end

  // tag identifiers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_tag_identifier_ff  <= VLAN_RST;
      second_tag_identifier_ff <= VLAN_RST;
    end else begin
      if (wr && hit_vl1) begin
        first_tag_identifier_ff <= merge_vl1[15:0];
      end
      if (wr && hit_vl2) begin
        second_tag_identifier_ff <= merge_vl2[15:0];
      end
    end
  end

  // wake enables and skip-address; ordinary reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_skip_address_filter_ff <= 1'b0;
      wake_frame_sleep_enable_ff  <= 1'b0;
      remote_wake_sleep_enable_ff <= 1'b0;
    end else if (wr && hit_wake) begin
      if (wb_sel_i[1]) begin
        wake_skip_address_filter_ff <= wb_dat_i[WK_SKIP_ADR];
      end
      if (wb_sel_i[0]) begin
        wake_frame_sleep_enable_ff  <= wb_dat_i[WK_FRM_EN];
        remote_wake_sleep_enable_ff <= wb_dat_i[WK_RMT_EN];
      end
    end
  end

  // ----------------------------------------------------------------
  // wake detection
  // ----------------------------------------------------------------
  logic ev_frm;
  logic ev_rmt;
  assign ev_frm = rx_evt_i.wake_frame & wake_frame_sleep_enable_ff
                  & (wake_skip_address_filter_ff | rx_evt_i.addr_pass);
  assign ev_rmt = rx_evt_i.remote_pkt & remote_wake_sleep_enable_ff;

  // flags live on power-on reset only so a soft reset keeps the cause
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      wake_frame_seen_flag_ff    <= 1'b0;
      remote_wake_packet_flag_ff <= 1'b0;
    end else begin
      wake_frame_seen_flag_ff    <= ev_frm | (wake_frame_seen_flag_ff & ~clr_frm);
      remote_wake_packet_flag_ff <= ev_rmt | (remote_wake_packet_flag_ff & ~clr_rmt);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_event_o <= 1'b0;
      sleep_mode_o <= 1'b0;
    end else begin
      wake_event_o <= ev_frm | ev_rmt;
      sleep_mode_o <= wake_frame_sleep_enable_ff | remote_wake_sleep_enable_ff;
    end
  end

  // ----------------------------------------------------------------
  // flow control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pause_tx_req_o     <= 1'b0;
      back_pressure_o    <= 1'b0;
      rx_pause_decoded_o <= 1'b0;
      rx_pause_filter_o  <= 1'b0;
    end else begin
      // dropping duplex mid-request withdraws it; busy still waits for done
      pause_tx_req_o     <= busy_ff & ~pause_tx_done_i & full_duplex_i & flow_control_on_ff;
      back_pressure_o    <= flow_control_on_ff & ~full_duplex_i;
      rx_pause_decoded_o <= rx_evt_i.pause_frame & flow_control_on_ff & full_duplex_i;
      rx_pause_filter_o  <= rx_evt_i.pause_frame & flow_control_on_ff & full_duplex_i
                            & pass_pause_frames_ff;
    end
  end

  assign pause_time_o        = pause_time_ff;
  assign phy_transfer_word_o = phy_word_ff;

  // ----------------------------------------------------------------
  // frame length limit
  // ----------------------------------------------------------------
  logic match_1;
  logic match_2;
  assign match_1 = rx_evt_i.tag != 16'h0000 && rx_evt_i.tag == first_tag_identifier_ff;
  assign match_2 = rx_evt_i.tag != 16'h0000 && rx_evt_i.tag == second_tag_identifier_ff;

  // limit holds until the next frame's tag bytes arrive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      max_frame_len_o <= LEN_PLAIN;
    end else if (rx_evt_i.tag_valid) begin
      if (match_2) begin
        max_frame_len_o <= LEN_VLAN_2;
      end else if (match_1) begin
        max_frame_len_o <= LEN_VLAN_1;
      end else begin
        max_frame_len_o <= LEN_PLAIN;
      end
    end
  end

  // ----------------------------------------------------------------
  // wake filter data port
  // ----------------------------------------------------------------
  mfv_wake_store #(
    .WORDS (WAKE_WORDS),
    .WIDTH (WAKE_WIDTH)
  ) u_store (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .access_i(req & hit_port),
    .write_i (wb_we_i),
    .sel_i   (wb_sel_i),
    .wdata_i (wb_dat_i),
    .rdata_o (port_rdata),
    .words_o (wake_filter_words_o)
  );

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_set = {ev_rmt, ev_frm, pause_tx_done_i & busy_ff};
  assign irq_clr = (wr && hit_sts && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0;

  // set beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sts_ff <= '0;
    end else begin
      irq_sts_ff <= irq_set | (irq_sts_ff & ~irq_clr);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= '0;
    end else if (wr && hit_mask && wb_sel_i[0]) begin
      irq_mask_ff <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // registered, so the line trails the status bit by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_sts_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // read mux and ack
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    unique case (1'b1)
      hit_phy:  nxt_rdata = {16'h0000, phy_word_ff};
      hit_flow: nxt_rdata = {pause_time_ff, 13'h0000, pass_pause_frames_ff,
                             flow_control_on_ff, busy_ff};
      hit_vl1:  nxt_rdata = {16'h0000, first_tag_identifier_ff};
      hit_vl2:  nxt_rdata = {16'h0000, second_tag_identifier_ff};
      hit_port: nxt_rdata = port_rdata;
      hit_wake: begin
        nxt_rdata[WK_SKIP_ADR] = wake_skip_address_filter_ff;
        nxt_rdata[WK_FRM_FLAG] = wake_frame_seen_flag_ff;
        nxt_rdata[WK_RMT_FLAG] = remote_wake_packet_flag_ff;
        nxt_rdata[WK_FRM_EN]   = wake_frame_sleep_enable_ff;
        nxt_rdata[WK_RMT_EN]   = remote_wake_sleep_enable_ff;
      end
      hit_sts:  nxt_rdata[IRQ_W-1:0] = irq_sts_ff;
      hit_mask: nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
      default:  nxt_rdata = '0;  // unmapped reads zero
    endcase
  end

  // every request, mapped or not, is acked one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= req;
      if (req && !wb_we_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_busy_clear;
    @(posedge clk_i) disable iff (rst_i)
    pause_tx_done_i && !busy_set |=> !busy_ff;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy stuck after pause sent");

  property p_pause_req;
    @(posedge clk_i) disable iff (rst_i)
    pause_tx_req_o |-> $past(busy_ff) && $past(full_duplex_i) && $past(flow_control_on_ff);
  endproperty
  a_pause_req: assert property (p_pause_req) else $error("pause request without cause");

  property p_back_pressure;
    @(posedge clk_i) disable iff (rst_i)
    ##1 back_pressure_o == ($past(flow_control_on_ff) && !$past(full_duplex_i));
  endproperty
  a_back_pressure: assert property (p_back_pressure) else $error("back-pressure wrong");

  property p_pause_filter;
    @(posedge clk_i) disable iff (rst_i)
    rx_evt_i.pause_frame && flow_control_on_ff && full_duplex_i
      |=> rx_pause_decoded_o && rx_pause_filter_o == $past(pass_pause_frames_ff);
  endproperty
  a_pause_filter: assert property (p_pause_filter) else $error("pause filter bit wrong");

  property p_len_first;
    @(posedge clk_i) disable iff (rst_i)
    rx_evt_i.tag_valid && match_1 && !match_2 |=> max_frame_len_o == LEN_VLAN_1;
  endproperty
  a_len_first: assert property (p_len_first) else $error("first tag limit wrong");

  property p_len_second;
    @(posedge clk_i) disable iff (rst_i)
    rx_evt_i.tag_valid && match_2 |=> max_frame_len_o == LEN_VLAN_2;
  endproperty
  a_len_second: assert property (p_len_second) else $error("second tag limit wrong");

  property p_wake_frame;
    @(posedge clk_i) disable iff (por_i)
    rx_evt_i.wake_frame && wake_frame_sleep_enable_ff && !rst_i
      && (rx_evt_i.addr_pass || wake_skip_address_filter_ff)
      |=> wake_frame_seen_flag_ff && wake_event_o;
  endproperty
  a_wake_frame: assert property (p_wake_frame) else $error("wake frame flag not set");

  property p_wake_addr;
    @(posedge clk_i) disable iff (rst_i || por_i)
    !wake_skip_address_filter_ff && !rx_evt_i.addr_pass && !rx_evt_i.remote_pkt
      |=> !wake_event_o;
  endproperty
  a_wake_addr: assert property (p_wake_addr) else $error("wake without address pass");

  property p_flag_keep;
    @(posedge clk_i) disable iff (por_i)
    rst_i && !ev_frm && !ev_rmt && !clr_frm && !clr_rmt
      |=> $stable(wake_frame_seen_flag_ff) && $stable(remote_wake_packet_flag_ff);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("wake flag lost on reset");

  property p_sleep;
    @(posedge clk_i) disable iff (rst_i)
    remote_wake_sleep_enable_ff |=> sleep_mode_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");

endmodule

// File: mfv_mac_model.sv
`timescale 1ns/10ps
module mfv_mac_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic req_i,
  input  wire logic slow_i,
  output logic      done_o
);
  logic [3:0] cnt_ff;
  // sends one pause frame per request; slow mode models a crowded wire
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i || done_o) begin
      cnt_ff <= 4'h0;
      done_o <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      done_o <= cnt_ff == (slow_i ? 4'h9 : 4'h1);
    end
  end
endmodule

// File: mfv_pkg.sv
package mfv_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_PHY_DATA  = 8'h18;
  localparam logic [7:0] ADR_FLOW      = 8'h1C;
  localparam logic [7:0] ADR_VLAN_1    = 8'h20;
  localparam logic [7:0] ADR_VLAN_2    = 8'h24;
  localparam logic [7:0] ADR_WAKE_DATA = 8'h28;
  localparam logic [7:0] ADR_WAKE_CTRL = 8'h2C;
  localparam logic [7:0] ADR_IRQ_STS   = 8'h30;
  localparam logic [7:0] ADR_IRQ_MASK  = 8'h34;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FC_BUSY_BIT  = 0;
  localparam int FC_ON_BIT    = 1;
  localparam int FC_PASS_BIT  = 2;
  localparam int FC_PAUSE_LSB = 16;
  localparam int WK_RMT_EN    = 1;
  localparam int WK_FRM_EN    = 2;
  localparam int WK_RMT_FLAG  = 5;
  localparam int WK_FRM_FLAG  = 6;
  localparam int WK_SKIP_ADR  = 9;

  // interrupt status / mask layout
  localparam int IRQ_W          = 3;
  localparam int IRQ_PAUSE_DONE = 0;
  localparam int IRQ_WAKE_FRM   = 1;
  localparam int IRQ_WAKE_RMT   = 2;

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [15:0] VLAN_RST    = 16'hFFFF;
  localparam logic [15:0] PAUSE_RST   = 16'h0000;
  localparam logic [10:0] LEN_PLAIN   = 11'h5EE;  // 1518 bytes
  localparam logic [10:0] LEN_VLAN_1  = 11'h5F2;  // 1522 bytes
  localparam logic [10:0] LEN_VLAN_2  = 11'h602;  // 1538 bytes
  localparam int          WAKE_WORDS  = 8;
  localparam int          WAKE_WIDTH  = 32;

  // receive-side events from the mac datapath
  typedef struct packed {
    logic        tag_valid;    // bytes 13/14 of frame available
    logic [15:0] tag;          // bytes 13 and 14
    logic        pause_frame;  // pause-control frame received
    logic        wake_frame;   // frame passed the wake-up filter
    logic        addr_pass;    // frame passed destination filter
    logic        remote_pkt;   // remote wake packet received
  } mfv_rx_evt_s;

  // byte-lane merge for wishbone sel
  function automatic logic [31:0] mfv_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// File: mfv_wake_store.sv
`timescale 1ns/10ps
module mfv_wake_store
  import mfv_pkg::*;
#(
  parameter int WORDS = WAKE_WORDS,
  parameter int WIDTH = WAKE_WIDTH
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   access_i,
  input  wire logic                   write_i,
  input  wire logic [3:0]             sel_i,
  input  wire logic [31:0]            wdata_i,
  output logic      [31:0]            rdata_o,
  output logic      [WORDS*WIDTH-1:0] words_o
);

  localparam int IW = $clog2(WORDS);

  // wrap relies on a natural power-of-two roll-over
  if (WORDS < 2 || (1 << IW) != WORDS || WIDTH != 32) begin : g_chk
    $error("wake store needs a power-of-two depth and 32-bit words");
  end

  logic [IW-1:0] idx_ff;
  logic [31:0]   mem_ff [WORDS];

  // ----------------------------------------------------------------
  // word index
  // ----------------------------------------------------------------
  // any port access moves on, reads included
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_ff <= '0;
    end else if (access_i) begin
      idx_ff <= idx_ff + 1'b1;
    end
  end

  // filter words, addressed by the index
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (access_i && write_i) begin
      mem_ff[idx_ff] <= mfv_merge(mem_ff[idx_ff], wdata_i, sel_i);
    end
  end

  assign rdata_o = mem_ff[idx_ff];

  for (genvar g = 0; g < WORDS; g++) begin : g_out
    assign words_o[g*WIDTH +: WIDTH] = mem_ff[g];
  end

  property p_idx_step;
    @(posedge clk_i) disable iff (rst_i)
    access_i |=> idx_ff == IW'($past(idx_ff) + 1'b1);
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("filter index did not advance");

endmodule

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
  import mfv_pkg::*;
  logic         clk_i, rst_i, por_i, cyc, stb, we, ack, fdx, done, slow, prd, req, bp, dec, filt, slp, wev, irq;
  logic [7:0]   adr;
  logic [3:0]   sel;
  logic [31:0]  dat, rdat, rd;
  logic [10:0]  len;
  logic [15:0]  pt, pw;
  logic [255:0] words;
  mfv_rx_evt_s  rx;
  int           err_count, n_checks;
  // sel defaults to all lanes; one scenario writes a single lane
  mfv_csr u_mfv_csr (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .full_duplex_i(fdx),
    .pause_tx_done_i(done), .phy_read_done_i(prd), .phy_read_word_i(16'hBEEF), .rx_evt_i(rx),
    .pause_tx_req_o(req), .pause_time_o(pt), .back_pressure_o(bp), .rx_pause_decoded_o(dec),
    .rx_pause_filter_o(filt), .max_frame_len_o(len), .phy_transfer_word_o(pw), .wake_filter_words_o(words),
    .sleep_mode_o(slp), .wake_event_o(wev), .irq_o(irq));
  mfv_mac_model u_mfv_mac_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .slow_i(slow), .done_o(done));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task complete_run;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; the wait is bounded so a dead slave ends the run
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (ack !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: no ack from slave", $time);
      complete_run();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // one-cycle receive event, returns when its registered outputs are visible
  task ev(input mfv_rx_evt_s e);
    @(posedge clk_i);
    rx <= e;
    @(posedge clk_i);
    rx <= '0;
    @(posedge clk_i);
  endtask
  task t_regs;
    wb(0, ADR_VLAN_2, '0);
    chk(rd, 32'h0000_FFFF);
    chk(32'(len), 32'h0000_05EE);
    wb(1, 8'h3C, 32'h1234_5678);
    wb(0, 8'h3C, '0);
    chk(rd, '0);
    @(posedge clk_i) prd <= 1'b1;
    @(posedge clk_i) prd <= 1'b0;
    wb(0, ADR_PHY_DATA, '0);
    chk(rd, 32'h0000_BEEF);
    wb(1, ADR_PHY_DATA, 32'h0000_1357);
    chk(32'(pw), 32'h0000_1357);
  endtask
  task t_pause;
    int i;
    fdx <= 1'b1;
    slow <= 1'b1;
    wb(1, ADR_IRQ_MASK, 32'h0000_0001);
    wb(1, ADR_FLOW, 32'h1234_0006);
    wb(0, ADR_FLOW, '0);
    chk(rd, 32'h1234_0006);
    wb(1, ADR_FLOW, 32'h1234_0007);
    chk(32'(pt), 32'h0000_1234);
    repeat (2) @(posedge clk_i);
    chk(32'(req), 32'h0000_0001);
    for (i = 0; i < 10; i++) begin
      wb(0, ADR_FLOW, '0);
      if (rd[0] === 1'b0) break;
    end
    chk(rd, 32'h1234_0006);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0000_0001);
    wb(1, ADR_IRQ_STS, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk(32'(irq), '0);
    slow <= 1'b0;
    wb(1, ADR_FLOW, 32'h1234_0007);
    repeat (4) @(posedge clk_i);
    wb(0, ADR_FLOW, '0);
    chk(rd, 32'h1234_0006);
    ev({17'h0_0000, 4'b1000});
    chk(32'({dec, filt}), 32'h0000_0003);
    wb(1, ADR_FLOW, 32'h1234_0002);
    ev({17'h0_0000, 4'b1000});
    chk(32'({dec, filt}), 32'h0000_0002);
    wb(1, ADR_FLOW, 32'hFFFF_0006, 4'h1);
    wb(0, ADR_FLOW, '0);
    chk(rd, 32'h1234_0006);
    fdx <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(32'(bp), 32'h0000_0001);
    wb(1, ADR_FLOW, '0);
    repeat (2) @(posedge clk_i);
    chk(32'(bp), '0);
  endtask
  task t_vlan;
    wb(1, ADR_VLAN_1, 32'h0000_8100);
    ev({1'b1, 16'h8100, 4'h0});
    chk(32'(len), 32'h0000_05F2);
    wb(1, ADR_VLAN_2, 32'h0000_9100);
    ev({1'b1, 16'h9100, 4'h0});
    chk(32'(len), 32'h0000_0602);
    wb(1, ADR_VLAN_1, '0);
    ev({1'b1, 16'h0000, 4'h0});
    chk(32'(len), 32'h0000_05EE);
  endtask
  task t_filter;
    int k;
    for (k = 0; k < 8; k++) wb(1, ADR_WAKE_DATA, 32'hA5A5_0000 | 32'(k));
    for (k = 0; k < 8; k++) chk(words[k*32 +: 32], 32'hA5A5_0000 | 32'(k));
    for (k = 0; k < 9; k++) begin
      wb(0, ADR_WAKE_DATA, '0);
      chk(rd, 32'hA5A5_0000 | 32'(k % 8));
    end
  endtask
  task t_wake;
    wb(1, ADR_IRQ_MASK, 32'h0000_0006);
    wb(1, ADR_WAKE_CTRL, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk(32'(slp), 32'h0000_0001);
    ev({17'h0_0000, 4'b0100});
    chk(32'(wev), '0);
    ev({17'h0_0000, 4'b0110});
    chk(32'(wev), 32'h0000_0001);
    wb(0, ADR_WAKE_CTRL, '0);
    chk(rd, 32'h0000_0044);
    chk(32'(irq), 32'h0000_0001);
    @(posedge clk_i) rst_i <= 1'b1;
    @(posedge clk_i) rst_i <= 1'b0;
    wb(0, ADR_WAKE_CTRL, '0);
    chk(rd, 32'h0000_0040);
    wb(1, ADR_WAKE_CTRL, 32'h0000_0246);
    ev({17'h0_0000, 4'b0100});
    chk(32'(wev), 32'h0000_0001);
    ev({17'h0_0000, 4'b0001});
    chk(32'(wev), 32'h0000_0001);
    wb(0, ADR_WAKE_CTRL, '0);
    chk(rd, 32'h0000_0266);
    @(posedge clk_i) por_i <= 1'b1;
    @(posedge clk_i) por_i <= 1'b0;
    wb(0, ADR_WAKE_CTRL, '0);
    chk(rd, 32'h0000_0206);
  endtask
  initial begin
    {rst_i, por_i, cyc, stb, we, fdx, slow, prd} = 8'hC0;
    {adr, dat, sel, rx, err_count, n_checks} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    t_regs();
    t_pause();
    t_vlan();
    t_filter();
    t_wake();
    complete_run();
  end
endmodule
